// ### design/iot_pkg.sv
// Shared constants and types for the programmable I/O tile storage logic.
package iot_pkg;

    // Storage elements in one tile: two per path, three paths.
    localparam int unsigned ELEM_COUNT = 6;
    // Element index of the first register of each path.
    localparam int unsigned IN_BASE = 0;
    localparam int unsigned OUT_BASE = 2;
    localparam int unsigned TRI_BASE = 4;
    // Stages of the pin synchroniser.
    localparam int unsigned SYNC_STAGES = 2;

    // Set/reset modes of one storage element.
    localparam logic [1:0] SRM_NONE = 2'h0;
    localparam logic [1:0] SRM_SET = 2'h1;
    localparam logic [1:0] SRM_RESET = 2'h2;
    localparam logic [1:0] SRM_BOTH = 2'h3;
    // Bit positions inside a set/reset mode code.
    localparam int unsigned SRM_SET_BIT = 0;
    localparam int unsigned SRM_RST_BIT = 1;

    // Bit positions of the control polarity vector.
    localparam int unsigned POL_CLK0 = 0;
    localparam int unsigned POL_CLK1 = 1;
    localparam int unsigned POL_ICE = 2;
    localparam int unsigned POL_OCE = 3;
    localparam int unsigned POL_TCE = 4;
    localparam int unsigned POL_SR = 5;
    localparam int unsigned POL_REV = 6;
    localparam int unsigned POL_WIDTH = 7;

    // Drive current codes 2, 4, 6, 8, 12, 16, 24 mA; 24 mA is the top code.
    localparam logic [2:0] DRIVE_MAX_CODE = 3'h6;
    localparam logic [2:0] DRIVE_RESET = 3'h3;

    // Route of the output value or three-state control to the pad buffer.
    typedef enum logic [1:0] {
        ROUTE_DIRECT = 2'b00,
        ROUTE_SINGLE = 2'b01,
        ROUTE_DDR    = 2'b10
    } iot_route_type;

    // Signalling configuration families that change the tile's options.
    typedef enum logic [2:0] {
        STD_LVTTL     = 3'b000,
        STD_LVCMOS    = 3'b001,
        STD_PCI       = 3'b010,
        STD_CI_CMOS   = 3'b011,
        STD_HALF_CMOS = 3'b100,
        STD_OTHER     = 3'b101
    } iot_std_type;

endpackage

// ### design/iot_elem_if.sv
// Signals that join the tile to one of its storage elements.
`timescale 1ns/1ps
`default_nettype none
interface iot_elem_if;
    logic d;        // Data to capture.
    logic clkLevel; // Element clock level after polarity.
    logic clkRise;  // One-cycle pulse on the element clock's active edge.
    logic ce;       // Clock enable after polarity.
    logic srAct;    // Shared set/reset input after polarity.
    logic revAct;   // Opposite state input after polarity.
    logic q;        // Stored value.
    modport store (input d, clkLevel, clkRise, ce, srAct, revAct, output q);
    modport tile (output d, clkLevel, clkRise, ce, srAct, revAct, input q);
endinterface
`default_nettype wire

// ### design/iot_store_elem.sv
// One configurable storage element: flip-flop or latch with set/reset.
`timescale 1ns/1ps
`default_nettype none
module iot_store_elem
    import iot_pkg::*;
(
    // Clock and reset.
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Element configuration.
    input  wire logic       latchMode,
    input  wire logic [1:0] srMode,
    input  wire logic       forceHigh,
    input  wire logic       initOverride,
    input  wire logic       initOne,
    input  wire logic       asyncSr,
    // Data and control from the tile.
    iot_elem_if.store       el
);
    import iot_pkg::*;

    logic qReg;   // Stored value.
    logic qNext;  // Value for the next edge.

    // Capture window: an edge for a flip-flop, the high level for a latch.
    wire captureEvt = latchMode ? el.clkLevel : el.clkRise;
    // the opposite state input forces the complement of the set/reset value.
    wire wantOne = (el.srAct & forceHigh) | (el.revAct & ~forceHigh);
    wire wantZero = (el.srAct & ~forceHigh) | (el.revAct & forceHigh);
    // only the modes that are configured may act.
    wire setReq = srMode[SRM_SET_BIT] & wantOne;
    wire rstReq = srMode[SRM_RST_BIT] & wantZero;
    // synchronous or asynchronous timing comes from the tile.
    wire srWindow = asyncSr | captureEvt;
    // initial value follows the force attribute unless overridden.
    wire initVal = initOverride ? initOne : forceHigh;

    // Next value; reset beats set, and set/reset beat data.
    always_comb begin
        qNext = qReg;
        if (srWindow && rstReq) begin
            qNext = 1'b0;
        end else if (srWindow && setReq) begin
            qNext = 1'b1;
        end else if (captureEvt && el.ce) begin
            qNext = el.d;
        end
    end

    // State register; configuration reset loads the initial value.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            qReg <= initVal;
        end else begin
            qReg <= qNext;
        end
    end

    assign el.q = qReg;

    // Reset wins whenever both requests are active in the window.
    reset_wins_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (srWindow && rstReq && setReq) |=> !qReg)
        else $error("Set beat reset in one storage element.");

    // Without an enabled capture or set/reset the value holds.
    elem_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!(srWindow && (rstReq || setReq)) && !(captureEvt && el.ce)) |=> $stable(qReg))
        else $error("Storage element changed without cause.");

    // After configuration reset the element holds its initial value.
    init_value_a: assert property (@(posedge sys_clk)
        !resetn |=> (qReg == $past(initVal)))
        else $error("Initial value not loaded.");

endmodule
`default_nettype wire

// ### design/iot_tile.sv
// I/O tile: six storage elements, path routing, pad and resistor control.
`timescale 1ns/1ps
`default_nettype none
module iot_tile
    import iot_pkg::*;
(
    // Clock and reset.
    input  wire logic                      sys_clk,
    input  wire logic                      resetn,
    // Configuration state.
    input  wire logic                      configDone,
    // Fabric clocks of the two DDR phases and pad input, asynchronous.
    input  wire logic                      fabricClk0,
    input  wire logic                      fabricClk1,
    input  wire logic                      padIn,
    // Fabric controls.
    input  wire logic                      inputClockEnable,
    input  wire logic                      outputClockEnable,
    input  wire logic                      tristateClockEnable,
    input  wire logic [2:0]                enableUsed,
    input  wire logic                      setResetInput,
    input  wire logic                      oppositeStateInput,
    input  wire logic [POL_WIDTH-1:0]      invertCtrl,
    // Fabric data.
    input  wire logic                      outData0,
    input  wire logic                      outData1,
    input  wire logic                      triData0,
    input  wire logic                      triData1,
    input  wire logic                      forwardClock,
    // Element attributes.
    input  wire logic [ELEM_COUNT-1:0]     latchMode,
    input  wire logic [2*ELEM_COUNT-1:0]   srMode,
    input  wire logic [ELEM_COUNT-1:0]     forceHighAttr,
    input  wire logic [ELEM_COUNT-1:0]     initOverride,
    input  wire logic [ELEM_COUNT-1:0]     powerOnOne,
    input  wire logic                      asyncSr,
    // Routing and pad options.
    input  wire iot_pkg::iot_route_type    outRoute,
    input  wire iot_pkg::iot_route_type    triRoute,
    input  wire iot_pkg::iot_std_type      ioStd,
    input  wire logic                      diffPair,
    input  wire logic                      pullUpSel,
    input  wire logic                      pullDownSel,
    input  wire logic                      keeperSel,
    input  wire logic [2:0]                driveSel,
    input  wire logic                      fastSlewSel,
    // Fabric-side results.
    output logic                           inDirect,
    output logic                           inQ0,
    output logic                           inQ1,
    // Pad side.
    output logic                           padOut,
    output logic                           padOe,
    output logic                           padOutN,
    output logic                           padOeN,
    output logic                           pullUpOn,
    output logic                           pullDownOn,
    output logic                           keeperOn,
    output logic                           keeperLevel,
    output logic [2:0]                     driveCode,
    output logic                           fastSlew,
    output logic                           driveCtrlValid
);
    import iot_pkg::*;

    // Two-flop synchronisers; stage one is read only by stage two.
    logic [SYNC_STAGES-1:0] clk0Sync_reg;
    logic [SYNC_STAGES-1:0] clk1Sync_reg;
    logic [SYNC_STAGES-1:0] padSync_reg;
    logic                   clk0Prev_reg;  // Previous polarity-adjusted clock 0.
    logic                   clk1Prev_reg;  // Previous polarity-adjusted clock 1.
    logic                   padOut_reg;    // Registered pad value.
    logic                   padOe_reg;     // Registered output enable.
    logic                   keeper_reg;    // Last driven or seen pad level.
    logic                   keeper_next;

    // each control input passes its own polarity select.
    wire clk0Lvl = clk0Sync_reg[1] ^ invertCtrl[POL_CLK0];
    wire clk1Lvl = clk1Sync_reg[1] ^ invertCtrl[POL_CLK1];
    wire srAct = setResetInput ^ invertCtrl[POL_SR];
    wire revAct = oppositeStateInput ^ invertCtrl[POL_REV];
    // the same active edge type on each of the two phase clocks.
    wire clk0Rise = clk0Lvl & ~clk0Prev_reg;
    wire clk1Rise = clk1Lvl & ~clk1Prev_reg;
    // an unused enable counts as asserted.
    wire iceAct = ~enableUsed[0] | (inputClockEnable ^ invertCtrl[POL_ICE]);
    wire oceAct = ~enableUsed[1] | (outputClockEnable ^ invertCtrl[POL_OCE]);
    wire tceAct = ~enableUsed[2] | (tristateClockEnable ^ invertCtrl[POL_TCE]);
    // clock forwarding launches one then zero through the output pair.
    wire oD0 = forwardClock ? 1'b1 : outData0;
    wire oD1 = forwardClock ? 1'b0 : outData1;

    // Synchroniser and edge history registers.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            clk0Sync_reg <= '0;
            clk1Sync_reg <= '0;
            padSync_reg  <= '0;
            clk0Prev_reg <= 1'b0;
            clk1Prev_reg <= 1'b0;
        end else begin
            clk0Sync_reg <= {clk0Sync_reg[0], fabricClk0};
            clk1Sync_reg <= {clk1Sync_reg[0], fabricClk1};
            padSync_reg  <= {padSync_reg[0], padIn};
            clk0Prev_reg <= clk0Lvl;
            clk1Prev_reg <= clk1Lvl;
        end
    end

    // Per-element data and enable selection.
    wire [ELEM_COUNT-1:0] elemD = {triData1, triData0, oD1, oD0,
                                   padSync_reg[1], padSync_reg[1]};
    wire [2:0]            pairCe = {tceAct, oceAct, iceAct};
    logic [ELEM_COUNT-1:0] elemQ;

    // six storage elements; even ones on clock 0, odd ones on clock 1.
    genvar gi;
    generate
        for (gi = 0; gi < ELEM_COUNT; gi = gi + 1) begin : gElem
            iot_elem_if link ();
            // alternate elements of a pair use the antiphase clock.
            assign link.clkLevel = (gi % 2 == 0) ? clk0Lvl : clk1Lvl;
            assign link.clkRise  = (gi % 2 == 0) ? clk0Rise : clk1Rise;
            assign link.d        = elemD[gi];
            assign link.ce       = pairCe[gi/2];
            assign link.srAct    = srAct;
            assign link.revAct   = revAct;
            assign elemQ[gi]     = link.q;
            // one timing choice for all six, attributes per element.
            iot_store_elem uElem (
                .sys_clk      (sys_clk),
                .resetn       (resetn),
                .latchMode    (latchMode[gi]),
                .srMode       (srMode[2*gi +: 2]),
                .forceHigh    (forceHighAttr[gi]),
                .initOverride (initOverride[gi]),
                .initOne      (powerOnOne[gi]),
                .asyncSr      (asyncSr),
                .el           (link.store)
            );
        end
    endgenerate

    // route selection for output value and three-state control.
    // in DDR mode clock 0 high selects its register, else the other.
    wire outSel = (outRoute == ROUTE_DDR) ? (clk0Lvl ? elemQ[OUT_BASE] : elemQ[OUT_BASE+1])
                : (outRoute == ROUTE_SINGLE) ? elemQ[OUT_BASE] : outData0;
    wire triSel = (triRoute == ROUTE_DDR) ? (clk0Lvl ? elemQ[TRI_BASE] : elemQ[TRI_BASE+1])
                : (triRoute == ROUTE_SINGLE) ? elemQ[TRI_BASE] : triData0;
    // no drive until configuration is done; high three-state means off.
    wire oeSel = configDone & ~triSel;

    // keeper exists only for LVTTL, LVCMOS and PCI.
    wire keeperStd = (ioStd == STD_LVTTL) | (ioStd == STD_LVCMOS) | (ioStd == STD_PCI);
    // drive and slew control only for LVTTL and LVCMOS.
    wire driveStd = (ioStd == STD_LVTTL) | (ioStd == STD_LVCMOS);
    wire [2:0] driveLim = (driveSel > DRIVE_MAX_CODE) ? DRIVE_MAX_CODE : driveSel;

    // keeper follows the driven level, else holds the sampled pad.
    always_comb begin
        keeper_next = keeper_reg;
        if (padOe_reg) begin
            keeper_next = padOut_reg;
        end else if (!keeperOn) begin
            keeper_next = padSync_reg[1];
        end
    end

    // Registered pad outputs.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            padOut_reg <= 1'b0;
            padOe_reg  <= 1'b0;
            keeper_reg <= 1'b0;
        end else begin
            padOut_reg <= outSel;
            padOe_reg  <= oeSel;
            keeper_reg <= keeper_next;
        end
    end

    // a tile may input and output; a pair adds the complement leg.
    assign inDirect = padSync_reg[1];
    assign inQ0 = elemQ[IN_BASE];
    assign inQ1 = elemQ[IN_BASE+1];
    assign padOut = padOut_reg;
    assign padOe = padOe_reg;
    assign padOutN = diffPair & ~padOut_reg;
    assign padOeN = diffPair & padOe_reg;
    // pulls in any standard, inactive before configuration.
    assign pullUpOn = configDone & pullUpSel;
    assign pullDownOn = configDone & pullDownSel & ~pullUpSel;
    // a selected pull overrides the keeper.
    assign keeperOn = configDone & keeperSel & keeperStd & ~pullUpSel & ~pullDownSel;
    assign keeperLevel = keeper_reg;
    assign driveCtrlValid = driveStd;
    assign driveCode = driveStd ? driveLim : DRIVE_RESET;
    assign fastSlew = driveStd & fastSlewSel;

    // Before configuration the pad is never driven.
    unconfig_hiz_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !$past(configDone) |-> !padOe)
        else $error("Pad driven before configuration.");

    // DDR output value follows the clock 0 phase, one cycle later.
    ddr_phase_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (outRoute == ROUTE_DDR) ##1 (outRoute == ROUTE_DDR) |->
        padOut == ($past(clk0Lvl) ? $past(elemQ[OUT_BASE]) : $past(elemQ[OUT_BASE+1])))
        else $error("DDR pad value from wrong register.");

    // Pulls override the keeper and the keeper needs a capable standard.
    keeper_prec_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        keeperOn |-> !(pullUpOn || pullDownOn) && keeperStd)
        else $error("Keeper active against a pull or standard.");

    // Drive control never exceeds the top current code.
    drive_limit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (driveCode <= DRIVE_MAX_CODE) && (!fastSlew || driveStd))
        else $error("Drive control out of range or unavailable.");

    // Forwarded clock: the clock 0 output register launches one on clock 0's edge.
    fwd_clock_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (forwardClock && clk0Rise && oceAct && srMode[2*OUT_BASE +: 2] == SRM_NONE)
        |=> elemQ[OUT_BASE])
        else $error("Forwarded clock high phase not captured.");

endmodule
`default_nettype wire

// ### dv/iot_far_model.sv
// Far-side model: antiphase fabric clock pair and the board wire of the pad.
`timescale 1ns/1ps
`default_nettype none
module iot_far_model #(
    parameter int HALF = 6 // Fabric clock half period in system cycles.
) (
    // Clock and bench controls.
    input  wire logic sys_clk,
    input  wire logic run,
    input  wire logic boardDrive,
    input  wire logic boardLevel,
    // Pad state from the tile.
    input  wire logic padOut,
    input  wire logic padOe,
    input  wire logic pullUpOn,
    input  wire logic pullDownOn,
    input  wire logic keeperOn,
    input  wire logic keeperLevel,
    // Toward the tile.
    output logic      fabricClk0,
    output logic      fabricClk1,
    output logic      padIn
);
    int   phase = 0;       // Position inside one fabric clock period.
    logic floatLvl = 1'b0; // Level of an undriven wire, changes every cycle.
    // Both clocks stand low between bursts and run in antiphase within one.
    // The first falling edge sets both low while the tile is still in reset.
    // antiphase clock pair
    always @(negedge sys_clk) begin
        floatLvl <= ~floatLvl;
        if (run) begin
            fabricClk0 <= (phase < HALF);
            fabricClk1 <= (phase >= HALF);
            phase <= (phase + 1) % (2 * HALF);
        end else begin
            fabricClk0 <= 1'b0;
            fabricClk1 <= 1'b0;
            phase <= 0;
        end
    end
    // Wire level: the tile's driver, the board, then pulls, then the keeper.
    // pulls beat keeper
    assign padIn = padOe ? padOut : boardDrive ? boardLevel : pullUpOn ? 1'b1 :
                   pullDownOn ? 1'b0 : keeperOn ? keeperLevel : floatLvl;
endmodule
`default_nettype wire

// ### dv/tb_iot_tile.sv
// Self-checking bench of the I/O tile storage, routing and pad control.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_iot_tile;
    import iot_pkg::*;
    localparam int HALF = 6; // Fabric clock half period in system cycles.
    // Bench state.
    logic sys_clk, resetn, configDone, run, boardDrive, boardLevel, midPad;
    int   mismatches = 0, checks = 0, cycles = 0, ones;
    // Tile inputs and the drive code output.
    logic fabricClk0, fabricClk1, padIn, inputClockEnable, outputClockEnable;
    logic tristateClockEnable, setResetInput, oppositeStateInput, outData0, outData1;
    logic triData0, triData1, forwardClock, asyncSr, diffPair, pullUpSel, pullDownSel;
    logic keeperSel, fastSlewSel;
    logic [2:0]              enableUsed, driveSel, driveCode;
    logic [POL_WIDTH-1:0]    invertCtrl;
    logic [ELEM_COUNT-1:0]   latchMode, forceHighAttr, initOverride, powerOnOne;
    logic [2*ELEM_COUNT-1:0] srMode;
    iot_route_type           outRoute, triRoute;
    iot_std_type             ioStd;
    // Tile outputs.
    logic inDirect, inQ0, inQ1, padOut, padOe, padOutN, padOeN, pullUpOn, pullDownOn;
    logic keeperOn, keeperLevel, fastSlew, driveCtrlValid;

    // The tile under test.
    iot_tile DUT (.sys_clk(sys_clk), .resetn(resetn), .configDone(configDone),
        .fabricClk0(fabricClk0), .fabricClk1(fabricClk1), .padIn(padIn),
        .inputClockEnable(inputClockEnable), .outputClockEnable(outputClockEnable),
        .tristateClockEnable(tristateClockEnable), .enableUsed(enableUsed),
        .setResetInput(setResetInput), .oppositeStateInput(oppositeStateInput),
        .invertCtrl(invertCtrl), .outData0(outData0), .outData1(outData1),
        .triData0(triData0), .triData1(triData1), .forwardClock(forwardClock),
        .latchMode(latchMode), .srMode(srMode), .forceHighAttr(forceHighAttr),
        .initOverride(initOverride), .powerOnOne(powerOnOne), .asyncSr(asyncSr),
        .outRoute(outRoute), .triRoute(triRoute), .ioStd(ioStd), .diffPair(diffPair),
        .pullUpSel(pullUpSel), .pullDownSel(pullDownSel), .keeperSel(keeperSel),
        .driveSel(driveSel), .fastSlewSel(fastSlewSel), .inDirect(inDirect),
        .inQ0(inQ0), .inQ1(inQ1), .padOut(padOut), .padOe(padOe), .padOutN(padOutN),
        .padOeN(padOeN), .pullUpOn(pullUpOn), .pullDownOn(pullDownOn),
        .keeperOn(keeperOn), .keeperLevel(keeperLevel), .driveCode(driveCode),
        .fastSlew(fastSlew), .driveCtrlValid(driveCtrlValid));
    // Fabric clocks and the board wire.
    iot_far_model #(.HALF(HALF)) farSide (.sys_clk(sys_clk), .run(run),
        .boardDrive(boardDrive), .boardLevel(boardLevel), .padOut(padOut),
        .padOe(padOe), .pullUpOn(pullUpOn), .pullDownOn(pullDownOn),
        .keeperOn(keeperOn), .keeperLevel(keeperLevel), .fabricClk0(fabricClk0),
        .fabricClk1(fabricClk1), .padIn(padIn));

    // System clock of 10 ns.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // A hang is cut short well beyond the expected run length.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            test_done();
        end
    end
    // Waits falling edges, where the bench changes inputs.
    task automatic waitCyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // One fabric clock period; the pad is sampled in the first clock's high phase.
    task automatic burst();
        run <= 1'b1;
        waitCyc(HALF);
        midPad = padOut;
        waitCyc(HALF);
        run <= 1'b0;
        waitCyc(6);
    endtask
    // Reports the end of one test.
    task automatic endTest(input string name);
        $display("test %s finished", name);
    endtask

    // Main sequence.
    initial begin
        {resetn, configDone, run, boardDrive, boardLevel, forwardClock, asyncSr} = '0;
        {setResetInput, oppositeStateInput, outData0, outData1, triData1} = '0;
        {diffPair, pullUpSel, pullDownSel, keeperSel, fastSlewSel} = '0;
        {inputClockEnable, outputClockEnable, tristateClockEnable, triData0} = '1;
        {enableUsed, driveSel, invertCtrl, latchMode, srMode} = {3'h7, 28'h0};
        {forceHighAttr, initOverride, powerOnOne} = {6'h03, 6'h02, 6'h00};
        outRoute = ROUTE_DIRECT;
        triRoute = ROUTE_DIRECT;
        ioStd = STD_LVTTL;
        waitCyc(2);
        `CHK(inQ0, 1'b1)
        `CHK(inQ1, 1'b0)
        `CHK(padOe, 1'b0)
        resetn = 1'b1;
        waitCyc(3);
        `CHK(padOe, 1'b0)
        {configDone, triData0, outData0} = 3'b101;
        waitCyc(2);
        `CHK({padOe, padOut}, 2'b11)
        endTest("reset and direct route");
        // Single register route with enable, unconnected enable and polarity.
        outRoute = ROUTE_SINGLE;
        outputClockEnable = 1'b0;
        burst();
        `CHK(padOut, 1'b0)
        enableUsed = 3'h5;
        burst();
        `CHK(padOut, 1'b1)
        {enableUsed, outputClockEnable, outData0, invertCtrl[POL_OCE]} = {3'h7, 3'b101};
        burst();
        `CHK(padOut, 1'b1)
        outputClockEnable = 1'b0;
        burst();
        `CHK(padOut, 1'b0)
        endTest("clock enables");
        // Shared set/reset on the output register, both modes.
        {srMode[5:4], forceHighAttr[2], asyncSr, setResetInput} = {SRM_BOTH, 3'b111};
        waitCyc(3);
        `CHK(padOut, 1'b1)
        oppositeStateInput = 1'b1;
        waitCyc(3);
        `CHK(padOut, 1'b0)
        {oppositeStateInput, setResetInput, invertCtrl[POL_SR]} = 3'b001;
        waitCyc(3);
        `CHK(padOut, 1'b1)
        {invertCtrl[POL_SR], asyncSr} = 2'b00;
        burst();
        `CHK(padOut, 1'b0)
        {setResetInput, outputClockEnable} = 2'b11;
        waitCyc(4);
        `CHK(padOut, 1'b0)
        burst();
        `CHK(padOut, 1'b1)
        setResetInput = 1'b0;
        endTest("set and reset");
        // Double-data-rate output, then a forwarded clock.
        outRoute = ROUTE_DDR;
        {outputClockEnable, outData0, outData1, srMode[5:4]} = {3'b010, SRM_NONE};
        burst();
        `CHK({midPad, padOut}, 2'b10)
        {outData0, outData1} = 2'b01;
        burst();
        `CHK({midPad, padOut}, 2'b01)
        {forwardClock, run} <= 2'b11;
        waitCyc(2 * HALF);
        ones = 0;
        repeat (4 * HALF) begin
            waitCyc(1);
            ones += int'(padOut);
        end
        `CHK(ones, 2 * HALF)
        {forwardClock, run} <= 2'b00;
        diffPair = 1'b1;
        waitCyc(6);
        `CHK({padOut, padOe, padOutN, padOeN}, 4'b0111)
        endTest("double data rate");
        // Input path: flop capture on both clocks, then a transparent latch.
        {triData0, boardDrive, boardLevel} = 3'b111;
        waitCyc(2);
        burst();
        `CHK({inDirect, inQ0, inQ1}, 3'b111)
        {latchMode[0], run} <= 2'b11;
        waitCyc(3);
        boardLevel = 1'b0;
        waitCyc(2 * HALF - 3);
        run <= 1'b0;
        waitCyc(6);
        `CHK({inDirect, inQ0}, 2'b00)
        endTest("input path");
        // Keeper holds the last driven level; pulls take over from it.
        outRoute = ROUTE_DIRECT;
        {boardDrive, keeperSel, triData0, outData0} = 4'b0101;
        waitCyc(3);
        triData0 = 1'b1;
        waitCyc(4);
        `CHK({keeperOn, keeperLevel, inDirect}, 3'b111)
        pullUpSel = 1'b1;
        waitCyc(1);
        `CHK({pullUpOn, keeperOn}, 2'b10)
        ioStd = STD_HALF_CMOS;
        {pullUpSel, pullDownSel} = 2'b01;
        waitCyc(1);
        `CHK({pullDownOn, keeperOn}, 2'b10)
        pullDownSel = 1'b0;
        waitCyc(1);
        `CHK({pullDownOn, keeperOn}, 2'b00)
        pullDownSel = 1'b1;
        endTest("pulls and keeper");
        // Drive strength and slew availability per standard.
        ioStd = STD_LVTTL;
        {driveSel, fastSlewSel} = {3'h7, 1'b1};
        waitCyc(1);
        `CHK({driveCtrlValid, driveCode, fastSlew}, {1'b1, DRIVE_MAX_CODE, 1'b1})
        ioStd = STD_LVCMOS;
        driveSel = 3'h2;
        waitCyc(1);
        `CHK({driveCtrlValid, driveCode}, {1'b1, 3'h2})
        ioStd = STD_CI_CMOS;
        waitCyc(1);
        `CHK({driveCtrlValid, driveCode, fastSlew}, {1'b0, DRIVE_RESET, 1'b0})
        // Leaving the configured state puts the pad back to high impedance.
        ioStd = STD_LVTTL;
        {triData0, configDone} = 2'b00;
        waitCyc(2);
        `CHK({padOe, pullDownOn, keeperOn}, 3'b000)
        endTest("drive and unconfigured pad");
        test_done();
    end
endmodule
`default_nettype wire
